// file: logic/dbp_debug_port.sv
// Two-wire debug and flash programming port, device side.
// Assumes the adapter clocks the link on debug_clock_input_i and that the
// testbench resolves the shared data wire from the output enable.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - The link uses only the adapter clock and one data line driven in turn by either side.
// - An eight-bit target select register written over the link picks the target of data commands.
// - Select 0x00 makes data reads return the read-only part identity.
// - Select 0x01 makes data reads return the read-only silicon revision.
// - Select 0x02 makes data reads and writes reach the flash program control register.
// - Select 0xB4 makes data reads and writes reach the flash program data register.
// - Select 0x80 makes data reads and writes reach the port 0 pin latch.
// - Selects 0xF1 and 0xA4 reach the port 0 input mode and output mode registers.
// - The program data register carries commands then operands, 0x08 page erase and 0x03 device erase.
// - Codes 0x06 block read and 0x07 block write are also valid and every other code is refused.
// - The halted state stalls peripherals and user code so the shared pins can be borrowed.
// - The debug clock shares the reset pin and the data line shares port 0 pin seven; here the clock has an input of its own apart from reset_n_i.
module dbp_debug_port #(
    parameter logic [7:0] PART_ID = 8'h5a,
    parameter logic [7:0] REVISION_ID = 8'h01,
    parameter int FIFO_DEPTH = 8
) (
    // Core clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Link pins
    input wire logic debug_clock_input_i,
    input wire logic debug_data_line_i,
    output logic debug_data_line_o,
    output logic debug_data_line_oe_o,
    // Flash controller stream
    output logic flash_valid_o,
    output logic flash_first_o,
    output logic [7:0] flash_byte_o,
    input wire logic flash_ready_i,
    input wire logic flash_done_i,
    input wire logic [7:0] flash_rdata_i,
    input wire logic flash_rdata_valid_i,
    // Core and pin control
    output logic core_halt_o,
    output logic pin7_user_en_o,
    output logic [6:0] flash_control_o,
    output logic [7:0] port0_latch_o,
    output logic [7:0] port0_in_mode_o,
    output logic [7:0] port0_out_mode_o
);
    initial
    begin
        if (FIFO_DEPTH < 2)
        begin
            $error("dbp_debug_port: FIFO_DEPTH must be at least 2");
        end
    end

    // Link domain state
    dbp_pkg::dbp_link_state_t link_state;
    logic [1:0] ins;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [7:0] debug_target_select;
    logic [7:0] tx;
    logic req_tgl;
    logic req_is_write;
    logic [7:0] req_addr;
    logic [7:0] req_wdata;
    logic ack_meta;
    logic ack_sync;
    logic ack_seen;
    logic ack_now;
    logic [1:0] next_ins;
    logic [7:0] next_byte;

    // Core domain state
    logic req_meta;
    logic req_sync;
    logic req_seen;
    logic req_new;
    logic accept;
    logic wr_en;
    logic ack_tgl;
    logic [7:0] core_rdata;
    logic [7:0] read_value;
    logic [6:0] flash_program_control;
    logic bad_cmd;
    logic cmd_phase;
    logic cmd_valid;
    logic [7:0] flash_read_byte;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [8:0] fifo_out_data;

    assign ack_now = ack_sync ^ ack_seen;
    assign next_ins = {debug_data_line_i, ins[1]};
    assign next_byte = {debug_data_line_i, shift[7:1]};

    // Ack toggle into the link domain
    always_ff @(posedge debug_clock_input_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end
        else
        begin
            ack_meta <= ack_tgl;
            ack_sync <= ack_meta;
        end
    end

    // Link framing on the adapter clock
    always_ff @(posedge debug_clock_input_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            link_state <= dbp_pkg::LINK_IDLE;
            ins <= 2'h0;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            debug_target_select <= dbp_pkg::TARGET_SELECT_RESET;
            tx <= 8'h00;
            req_tgl <= 1'b0;
            req_is_write <= 1'b0;
            req_addr <= 8'h00;
            req_wdata <= 8'h00;
            ack_seen <= 1'b0;
            debug_data_line_o <= 1'b0;
            debug_data_line_oe_o <= 1'b0;
        end
        else
        begin
            case (link_state)
                dbp_pkg::LINK_IDLE:
                begin
                    if (!debug_data_line_i)
                    begin
                        link_state <= dbp_pkg::LINK_INSTR;
                        bit_cnt <= 4'h0;
                    end
                end
                dbp_pkg::LINK_INSTR:
                begin
                    ins <= next_ins;
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == dbp_pkg::INS_LAST_BIT)
                    begin
                        bit_cnt <= 4'h0;
                        case (next_ins)
                            dbp_pkg::INS_ADDR_READ:
                            begin
                                tx <= debug_target_select;
                                link_state <= dbp_pkg::LINK_DATA_OUT;
                            end
                            dbp_pkg::INS_DATA_READ:
                            begin
                                req_tgl <= ~req_tgl;
                                req_is_write <= 1'b0;
                                req_addr <= debug_target_select;
                                link_state <= dbp_pkg::LINK_WAIT;
                            end
                            default:
                            begin
                                link_state <= dbp_pkg::LINK_DATA_IN;
                            end
                        endcase
                    end
                end
                dbp_pkg::LINK_DATA_IN:
                begin
                    shift <= next_byte;
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == dbp_pkg::BYTE_LAST_BIT)
                    begin
                        bit_cnt <= 4'h0;
                        if (ins == dbp_pkg::INS_ADDR_WRITE)
                        begin
                            debug_target_select <= next_byte;
                            link_state <= dbp_pkg::LINK_IDLE;
                        end
                        else
                        begin
                            req_tgl <= ~req_tgl;
                            req_is_write <= 1'b1;
                            req_addr <= debug_target_select;
                            req_wdata <= next_byte;
                            link_state <= dbp_pkg::LINK_WAIT;
                        end
                    end
                end
                dbp_pkg::LINK_WAIT:
                begin
                    debug_data_line_oe_o <= 1'b1;
                    debug_data_line_o <= ack_now;
                    if (ack_now)
                    begin
                        ack_seen <= ack_sync;
                        tx <= core_rdata;
                        bit_cnt <= req_is_write ? dbp_pkg::BYTE_BITS : 4'h0;
                        link_state <= dbp_pkg::LINK_DATA_OUT;
                    end
                end
                dbp_pkg::LINK_DATA_OUT:
                begin
                    if (bit_cnt == dbp_pkg::BYTE_BITS)
                    begin
                        debug_data_line_oe_o <= 1'b0;
                        debug_data_line_o <= 1'b0;
                        bit_cnt <= 4'h0;
                        link_state <= dbp_pkg::LINK_IDLE;
                    end
                    else
                    begin
                        debug_data_line_oe_o <= 1'b1;
                        debug_data_line_o <= tx[0];
                        tx <= {1'b0, tx[7:1]};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                default:
                begin
                    link_state <= dbp_pkg::LINK_IDLE;
                end
            endcase
        end
    end

    // Line idles released between frames
    a_line_released: assert property (@(posedge debug_clock_input_i) disable iff (!reset_n_i)
        (link_state == dbp_pkg::LINK_IDLE) |-> !debug_data_line_oe_o)
        else $error("data line driven while link idle");

    // Request toggle into the core domain
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
        end
        else
        begin
            req_meta <= req_tgl;
            req_sync <= req_meta;
        end
    end

    assign req_new = req_sync ^ req_seen;
    assign accept = req_new && !(req_is_write && req_addr == dbp_pkg::SEL_FLASH_PROGRAM_DATA && !fifo_in_ready);
    assign wr_en = accept && req_is_write;
    assign cmd_valid = (req_wdata == dbp_pkg::CMD_BLOCK_READ) || (req_wdata == dbp_pkg::CMD_BLOCK_WRITE) ||
        (req_wdata == dbp_pkg::CMD_PAGE_ERASE) || (req_wdata == dbp_pkg::CMD_DEVICE_ERASE);
    assign fifo_in_valid = wr_en && req_addr == dbp_pkg::SEL_FLASH_PROGRAM_DATA && (!cmd_phase || cmd_valid);

    // Read selection
    always_comb
    begin
        case (req_addr)
            dbp_pkg::SEL_PART_IDENTITY: read_value = PART_ID;
            dbp_pkg::SEL_SILICON_REVISION: read_value = REVISION_ID;
            dbp_pkg::SEL_FLASH_PROGRAM_CONTROL: read_value = {bad_cmd, flash_program_control};
            dbp_pkg::SEL_FLASH_PROGRAM_DATA: read_value = flash_read_byte;
            dbp_pkg::SEL_PORT0_LATCH: read_value = port0_latch_o;
            dbp_pkg::SEL_PORT0_IN_MODE: read_value = port0_in_mode_o;
            dbp_pkg::SEL_PORT0_OUT_MODE: read_value = port0_out_mode_o;
            default: read_value = 8'h00;
        endcase
    end

    // Request completion and answer
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            req_seen <= 1'b0;
            ack_tgl <= 1'b0;
            core_rdata <= 8'h00;
        end
        else if (accept)
        begin
            req_seen <= req_sync;
            ack_tgl <= ~ack_tgl;
            core_rdata <= req_is_write ? 8'h00 : read_value;
        end
    end

    // Port 0 registers
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            port0_latch_o <= dbp_pkg::PORT0_LATCH_RESET;
            port0_in_mode_o <= dbp_pkg::PORT0_IN_MODE_RESET;
            port0_out_mode_o <= dbp_pkg::PORT0_OUT_MODE_RESET;
        end
        else if (wr_en)
        begin
            case (req_addr)
                dbp_pkg::SEL_PORT0_LATCH: port0_latch_o <= req_wdata;
                dbp_pkg::SEL_PORT0_IN_MODE: port0_in_mode_o <= req_wdata;
                dbp_pkg::SEL_PORT0_OUT_MODE: port0_out_mode_o <= req_wdata;
                default: port0_latch_o <= port0_latch_o;
            endcase
        end
    end

    // Flash program control and refused command flag
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            flash_program_control <= dbp_pkg::FLASH_CONTROL_RESET;
            bad_cmd <= 1'b0;
        end
        else
        begin
            if (wr_en && req_addr == dbp_pkg::SEL_FLASH_PROGRAM_CONTROL)
            begin
                flash_program_control <= req_wdata[6:0];
            end
            if (wr_en && req_addr == dbp_pkg::SEL_FLASH_PROGRAM_DATA && cmd_phase && !cmd_valid)
            begin
                bad_cmd <= 1'b1;
            end
            else if (wr_en && req_addr == dbp_pkg::SEL_FLASH_PROGRAM_CONTROL)
            begin
                bad_cmd <= 1'b0;
            end
        end
    end

    // Command then operand sequencing
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cmd_phase <= 1'b1;
        end
        else if (flash_done_i)
        begin
            cmd_phase <= 1'b1;
        end
        else if (fifo_in_valid && cmd_phase)
        begin
            cmd_phase <= 1'b0;
        end
    end

    // Byte returned by the flash controller
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            flash_read_byte <= 8'h00;
        end
        else if (flash_rdata_valid_i)
        begin
            flash_read_byte <= flash_rdata_i;
        end
    end

    // Halt and pin borrowing
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            core_halt_o <= 1'b0;
            pin7_user_en_o <= 1'b1;
            flash_control_o <= dbp_pkg::FLASH_CONTROL_RESET;
        end
        else
        begin
            core_halt_o <= flash_program_control[dbp_pkg::CTL_HALT_BIT];
            pin7_user_en_o <= !flash_program_control[dbp_pkg::CTL_HALT_BIT];
            flash_control_o <= flash_program_control;
        end
    end

    dbp_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i({cmd_phase, req_wdata}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    assign fifo_out_ready = !flash_valid_o || flash_ready_i;

    // Output stage toward the flash controller
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            flash_valid_o <= 1'b0;
            flash_first_o <= 1'b0;
            flash_byte_o <= 8'h00;
        end
        else if (fifo_out_valid && fifo_out_ready)
        begin
            flash_valid_o <= 1'b1;
            flash_first_o <= fifo_out_data[8];
            flash_byte_o <= fifo_out_data[7:0];
        end
        else if (flash_ready_i)
        begin
            flash_valid_o <= 1'b0;
        end
    end

    // Checks
    a_part_id_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        accept && !req_is_write && req_addr == dbp_pkg::SEL_PART_IDENTITY |=> core_rdata == PART_ID)
        else $error("part identity read wrong");
    a_revision_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        accept && !req_is_write && req_addr == dbp_pkg::SEL_SILICON_REVISION |=> core_rdata == REVISION_ID)
        else $error("silicon revision read wrong");
    a_control_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_en && req_addr == dbp_pkg::SEL_FLASH_PROGRAM_CONTROL |=> ##1 flash_control_o == $past(req_wdata[6:0], 2))
        else $error("control write not seen at output");
    a_latch_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_en && req_addr == dbp_pkg::SEL_PORT0_LATCH |=> port0_latch_o == $past(req_wdata))
        else $error("port latch write lost");
    a_mode_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_en && req_addr == dbp_pkg::SEL_PORT0_OUT_MODE |=> port0_out_mode_o == $past(req_wdata))
        else $error("output mode write lost");
    a_erase_accepted: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_en && req_addr == dbp_pkg::SEL_FLASH_PROGRAM_DATA && cmd_phase && !flash_done_i &&
        req_wdata == dbp_pkg::CMD_PAGE_ERASE |=> !cmd_phase)
        else $error("page erase command not taken");
    a_bad_command: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_en && req_addr == dbp_pkg::SEL_FLASH_PROGRAM_DATA && cmd_phase && !cmd_valid |=> bad_cmd && cmd_phase)
        else $error("invalid command not refused");
    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        accept && !req_is_write && req_addr == 8'h55 |=> core_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_full_stalls: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        req_new && req_is_write && req_addr == dbp_pkg::SEL_FLASH_PROGRAM_DATA && !fifo_in_ready |=> $stable(ack_tgl))
        else $error("data write answered while fifo full");
    a_halt_follows: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(flash_program_control[dbp_pkg::CTL_HALT_BIT]) |=> core_halt_o ##1 core_halt_o || !flash_program_control[0])
        else $error("halt did not follow control");
    a_pin_borrowed: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        core_halt_o |-> !pin7_user_en_o)
        else $error("pin seven left to user while halted");

endmodule
`default_nettype wire

// file: logic/dbp_fifo.sv
// Small synchronous FIFO in flip-flops with valid and ready on both sides.
// Assumes one clock and the asynchronous active-low reset of its user.
`timescale 1ns/1ps
`default_nettype none
module dbp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
        begin
            $error("dbp_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready_o = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
    assign out_valid_o = (wr_ptr != rd_ptr);
    assign out_data_o = store[rd_ptr[AW-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Storage
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            store[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// file: logic/dbp_pkg.sv
// Constants for the two-wire debug and flash programming port.
// Assumes the includer writes every use as dbp_pkg::name.
package dbp_pkg;

    // Target select values
    localparam logic [7:0] SEL_PART_IDENTITY = 8'h00;
    localparam logic [7:0] SEL_SILICON_REVISION = 8'h01;
    localparam logic [7:0] SEL_FLASH_PROGRAM_CONTROL = 8'h02;
    localparam logic [7:0] SEL_FLASH_PROGRAM_DATA = 8'hb4;
    localparam logic [7:0] SEL_PORT0_LATCH = 8'h80;
    localparam logic [7:0] SEL_PORT0_IN_MODE = 8'hf1;
    localparam logic [7:0] SEL_PORT0_OUT_MODE = 8'ha4;

    // Flash command codes
    localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
    localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
    localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;

    // Link instruction codes, sent first bit first
    localparam logic [1:0] INS_DATA_READ = 2'h0;
    localparam logic [1:0] INS_DATA_WRITE = 2'h1;
    localparam logic [1:0] INS_ADDR_READ = 2'h2;
    localparam logic [1:0] INS_ADDR_WRITE = 2'h3;

    // Field positions and counts
    localparam int CTL_HALT_BIT = 0;
    localparam int CTL_BAD_CMD_BIT = 7;
    localparam logic [3:0] INS_LAST_BIT = 4'h1;
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Values after reset
    localparam logic [7:0] TARGET_SELECT_RESET = 8'h00;
    localparam logic [6:0] FLASH_CONTROL_RESET = 7'h00;
    localparam logic [7:0] PORT0_LATCH_RESET = 8'hff;
    localparam logic [7:0] PORT0_IN_MODE_RESET = 8'h00;
    localparam logic [7:0] PORT0_OUT_MODE_RESET = 8'h00;

    // Link states
    typedef enum logic [4:0] {
        LINK_IDLE = 5'b00001,
        LINK_INSTR = 5'b00010,
        LINK_DATA_IN = 5'b00100,
        LINK_WAIT = 5'b01000,
        LINK_DATA_OUT = 5'b10000
    } dbp_link_state_t;

endpackage

// file: testbench/dbp_flash_model.sv
// Flash controller stand-in that takes every byte while hold_i is low and ends each command on its first operand.
// Assumes the core clock and reset of the port.
`timescale 1ns/1ps
`default_nettype none
module dbp_flash_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Byte stream
    input wire logic valid_i,
    input wire logic first_i,
    input wire logic [7:0] byte_i,
    input wire logic hold_i,
    output logic ready_o,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic rdata_valid_o,
    // Log of commands seen
    output logic [7:0] last_cmd_o,
    output logic [7:0] cmd_count_o
);
    logic take;
    // Back-pressure on demand so the port's fifo can fill
    assign ready_o = !hold_i;
    assign take = valid_i && ready_o;
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            done_o <= 1'b0;
            rdata_valid_o <= 1'b0;
            rdata_o <= 8'h00;
            last_cmd_o <= 8'h00;
            cmd_count_o <= 8'h00;
        end
        else
        begin
            done_o <= take && !first_i;
            rdata_valid_o <= take && !first_i;
            if (take && first_i)
            begin
                last_cmd_o <= byte_i;
                cmd_count_o <= cmd_count_o + 8'h01;
            end
            if (take && !first_i)
                rdata_o <= ~byte_i;
        end
    end
endmodule
`default_nettype wire

// file: testbench/two_wire_debug_flash_port_tb.sv
// Link-level tests of the debug port with a flash stand-in.
// Assumes the port's link protocol and a pulled-up data wire.
`timescale 1ns/1ps
`default_nettype none
module two_wire_debug_flash_port_tb;
    logic clk_i = 0, reset_n_i = 0, lck = 0, host_oe = 1, host_val = 1, hold = 0;
    logic dout, oe, fv, ff, fr, fd, frv, halt, p7;
    logic [7:0] fb, frd, lat, im, om, lcmd, ccnt, rd;
    logic [6:0] fctl;
    logic [7:0] sels[4] = '{8'h02, 8'h80, 8'hf1, 8'ha4};
    logic [7:0] vals[4] = '{8'h41, 8'ha5, 8'h3c, 8'hc3};
    logic [7:0] cmds[4] = '{8'h06, 8'h07, 8'h08, 8'h03};
    int mismatches = 0, total_checks = 0;
    wire line = oe ? dout : (host_oe ? host_val : 1'b1);
    dbp_debug_port #(.PART_ID(8'h5a), .REVISION_ID(8'h01), .FIFO_DEPTH(8)) u_dut (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .debug_clock_input_i(lck), .debug_data_line_i(line), .debug_data_line_o(dout),
        .debug_data_line_oe_o(oe), .flash_valid_o(fv), .flash_first_o(ff), .flash_byte_o(fb), .flash_ready_i(fr),
        .flash_done_i(fd), .flash_rdata_i(frd), .flash_rdata_valid_i(frv), .core_halt_o(halt),
        .pin7_user_en_o(p7), .flash_control_o(fctl), .port0_latch_o(lat), .port0_in_mode_o(im),
        .port0_out_mode_o(om));
    dbp_flash_model u_flash (.clk_i(clk_i), .reset_n_i(reset_n_i), .valid_i(fv), .first_i(ff), .byte_i(fb),
        .ready_o(fr), .done_o(fd), .rdata_o(frd), .rdata_valid_o(frv), .last_cmd_o(lcmd), .cmd_count_o(ccnt),
        .hold_i(hold));
    initial
    begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Link clock runs only when a task calls tick, inside frames and between them; the reset pin is only an input
    task automatic tick();
        #5 lck = 1;
        #7 lck = 0;
    endtask
    task automatic send(input logic b);
        host_val = b;
        tick();
    endtask
    task automatic xfer(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rdv);
        int n;
        rdv = 8'h00;
        host_oe = 1;
        send(1'b0);
        send(ins[0]);
        send(ins[1]);
        if (ins[0])
            for (int i = 0; i < 8; i++) send(wd[i]);
        host_oe = 0;
        if (ins == dbp_pkg::INS_ADDR_WRITE) return;
        n = 0;
        if (ins != dbp_pkg::INS_ADDR_READ)
        begin
            do
            begin
                tick();
                n++;
            end while (line !== 1'b1 && n < 300);
            chk({15'h0, line}, 16'h0001);
        end
        if (!ins[0])
            for (int i = 0; i < 8; i++)
            begin
                tick();
                rdv[i] = line;
            end
        tick();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(dbp_pkg::INS_ADDR_WRITE, a, rd);
        xfer(dbp_pkg::INS_DATA_WRITE, d, rd);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        xfer(dbp_pkg::INS_ADDR_WRITE, a, rd);
        xfer(dbp_pkg::INS_DATA_READ, 8'h00, rd);
        chk(rd, exp);
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge clk_i);
        reset_n_i = 1;
        repeat (3) tick();
        chk({halt, p7, lat}, 16'h01ff);
        rdchk(dbp_pkg::SEL_PART_IDENTITY, 8'h5a);
        rdchk(dbp_pkg::SEL_SILICON_REVISION, 8'h01);
        wr(dbp_pkg::SEL_PART_IDENTITY, 8'h33);
        rdchk(dbp_pkg::SEL_PART_IDENTITY, 8'h5a);
        for (int i = 0; i < 4; i++)
        begin
            wr(sels[i], vals[i]);
            rdchk(sels[i], vals[i]);
        end
        chk({halt, p7, lat}, 16'h02a5);
        chk({1'b0, fctl, om}, 16'h41c3);
        chk(im, 8'h3c);
        wr(8'h55, 8'h77);
        rdchk(8'h55, 8'h00);
        xfer(dbp_pkg::INS_ADDR_READ, 8'h00, rd);
        chk(rd, 8'h55);
        xfer(dbp_pkg::INS_ADDR_WRITE, dbp_pkg::SEL_FLASH_PROGRAM_DATA, rd);
        for (int i = 0; i < 4; i++)
        begin
            xfer(dbp_pkg::INS_DATA_WRITE, cmds[i], rd);
            xfer(dbp_pkg::INS_DATA_WRITE, 8'h10 + 8'(i), rd);
        end
        chk({lcmd, ccnt}, 16'h0304);
        xfer(dbp_pkg::INS_DATA_READ, 8'h00, rd);
        chk(rd, 8'hec);
        xfer(dbp_pkg::INS_DATA_WRITE, 8'h42, rd);
        chk(ccnt, 8'h04);
        rdchk(dbp_pkg::SEL_FLASH_PROGRAM_CONTROL, 8'hc1);
        wr(dbp_pkg::SEL_FLASH_PROGRAM_CONTROL, 8'h00);
        rdchk(dbp_pkg::SEL_FLASH_PROGRAM_CONTROL, 8'h00);
        chk({halt, p7}, 16'h0001);
        // Stalled flash side: fill the fifo, the next data write waits for room
        xfer(dbp_pkg::INS_ADDR_WRITE, dbp_pkg::SEL_FLASH_PROGRAM_DATA, rd);
        @(negedge clk_i) hold = 1;
        xfer(dbp_pkg::INS_DATA_WRITE, 8'h07, rd);
        for (int i = 0; i < 8; i++)
        begin
            xfer(dbp_pkg::INS_DATA_WRITE, 8'h20 + 8'(i), rd);
        end
        fork
            xfer(dbp_pkg::INS_DATA_WRITE, 8'h28, rd);
            begin
                repeat (250) @(negedge clk_i);
                hold = 0;
            end
        join
        chk({lcmd, ccnt}, 16'h0705);
        xfer(dbp_pkg::INS_DATA_READ, 8'h00, rd);
        chk(rd, 8'hd7);
        close_out();
    end
    initial
    begin
        #200000;
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
